/* File: verilog/sps_pkg.sv */
// shared constants and types for the signal phase sequencer
package sps_pkg;
  localparam int NPH = 8;
  localparam int NOVL = 4;
  localparam int NPRM = 9;
  localparam int AW = 12;
  localparam int DW = 32;

  // timebase: one interval tick every 100 ms at 40 MHz
  localparam int CLK_KHZ = 40000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_KHZ * TICK_MS;

  // register map
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_OVL = 12'h004;
  localparam logic [11:0] A_STAT = 12'h008;
  localparam logic [11:0] A_CALL = 12'h00c;
  localparam logic [2:0] PRM_PAGE = 3'h1;
  localparam int PH_LSB = 6;
  localparam int IX_LSB = 2;
  localparam int CTRL_W = 8;
  localparam int RESTART_BIT = 8;

  // phase table entries
  localparam logic [3:0] P_MODE = 4'h0;
  localparam logic [3:0] P_MIN = 4'h1;
  localparam logic [3:0] P_EXT = 4'h2;
  localparam logic [3:0] P_MAX1 = 4'h3;
  localparam logic [3:0] P_MAX2 = 4'h4;
  localparam logic [3:0] P_YEL = 4'h5;
  localparam logic [3:0] P_RED = 4'h6;
  localparam logic [3:0] P_WALK = 4'h7;
  localparam logic [3:0] P_PCLR = 4'h8;

  // phase demand modes
  localparam logic [2:0] M_LOCK = 3'h0;
  localparam logic [2:0] M_NONLOCK = 3'h1;
  localparam logic [2:0] M_VREC = 3'h2;
  localparam logic [2:0] M_MAXREC = 3'h3;
  localparam logic [2:0] M_PEDREC = 3'h4;

  // initial interval after power-up or restart
  localparam logic [1:0] I_GRN = 2'h0;
  localparam logic [1:0] I_YEL = 2'h1;
  localparam logic [1:0] I_RED = 2'h2;

  localparam logic [7:0] SERVED_RST = 8'h11;
  localparam logic [31:0] OVL_RST = 32'h00000000;

  typedef enum logic [4:0] {
    ST_GREEN = 5'h01,
    ST_YEL = 5'h02,
    ST_RED = 5'h04,
    ST_SEL = 5'h08,
    ST_ALLRED = 5'h10
  } sps_st_t;

  typedef struct packed {
    logic [2:0] init_step;
    logic [1:0] init_int;
    logic single_ring;
    logic red_rest;
    logic alt_max;
  } sps_ctrl_t;

  localparam sps_ctrl_t CTRL_RST = 8'h00;

  // default durations in ticks
  function automatic logic [7:0] sps_prm_def(input logic [3:0] i);
    case (i)
      P_MIN: return 8'h32;
      P_EXT: return 8'h1e;
      P_MAX1: return 8'hc8;
      P_MAX2: return 8'hfa;
      P_YEL: return 8'h23;
      P_RED: return 8'h0f;
      P_WALK: return 8'h46;
      P_PCLR: return 8'h78;
      default: return 8'h00;
    endcase
  endfunction

  // phases timed together in one step; never two of one ring
  function automatic logic [7:0] sps_step_mask(input logic [2:0] s,
                                               input logic single);
    if (single) begin
      return 8'h01 << s;
    end
    return 8'h11 << s[1:0];
  endfunction

  function automatic logic sps_prm_hit(input logic [11:0] a);
    return a[11:9] == PRM_PAGE && a[IX_LSB+:4] < 4'(NPRM) &&
           a[1:0] == 2'h0;
  endfunction
endpackage

/* File: verilog/sps_core.sv */
// phase sequencer: calls, interval timing, step order and signal outputs
//
// Overview of operation
// - max recall serves to max green, rests green
// - ped recall serves walk without any call
// - vehicle recall calls whenever phase not green
// - non-locking call follows detector only
// - locking call holds until phase served
// - actuation after min green extends green
// - each actuation reloads the full extension
// - unexpired extension at termination keeps call
// - two max limits, started by conflicting call
// - alternate max by input or control bit
// - termination passes yellow then red clearance
// - button registers call whenever walk not shown
// - ped call held until walk given
// - ped call recycles walk without conflicting demand
// - don't walk steady outside walk and clearance
// - no service without call, rest on last
// - red rest option goes all red
// - dual ring or single ring, eight phases
// - serve one phase or compatible pair
// - skip undemanded steps, apply recall modes
// - four overlaps follow programmable phase sets
// - reset or restart starts selected interval, calls
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module sps_core #(
  parameter int unsigned TICK_CYC = sps_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [7:0] veh_det,
  input wire logic [7:0] ped_btn,
  input wire logic alt_max_in,
  input wire logic ext_restart,
  output logic [7:0] sig_green,
  output logic [7:0] sig_yellow,
  output logic [7:0] sig_red,
  output logic [7:0] ped_walk,
  output logic [7:0] ped_clear,
  output logic [7:0] ped_hold,
  output logic [3:0] ovl_green,
  output logic [3:0] ovl_yellow,
  output logic [3:0] ovl_red
);
  localparam int TCW = $clog2(TICK_CYC);

  logic [TCW-1:0] tick_cnt_ff;
  logic tick;
  sps_pkg::sps_ctrl_t ctrl_ff, rs_cfg;
  logic [31:0] ovl_ff;
  logic [7:0] prm_ff [sps_pkg::NPH][sps_pkg::NPRM];
  logic [31:0] rdata_ff;
  sps_pkg::sps_st_t st_ff;
  logic ent_ff;
  logic [2:0] step_ff;
  logic [7:0] served_ff;
  logic [7:0] cl_cnt_ff;
  logic restart;
  logic [7:0] grn, yel, demand, done, walk_on, pclr_on, vcall, pcall;
  logic conflict, any_dem, term, found;
  logic [2:0] nxt_step;
  logic [7:0] yel_max, red_max;
  logic [3:0] ovl_g, ovl_y;
  logic [7:0] grn_o_ff, yel_o_ff, red_o_ff, walk_o_ff, pclr_o_ff, hold_o_ff;
  logic [3:0] og_ff, oy_ff, or_ff;

  // common timebase
  assign tick = tick_cnt_ff == TCW'(TICK_CYC - 1);

  always_ff @(posedge clk) begin
    if (reset || tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  // register port
  assign restart = ext_restart || (wr && addr == sps_pkg::A_CTRL &&
                   wdata[sps_pkg::RESTART_BIT]);
  assign rs_cfg = (wr && addr == sps_pkg::A_CTRL) ?
                  wdata[sps_pkg::CTRL_W-1:0] : ctrl_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= sps_pkg::CTRL_RST;
      ovl_ff <= sps_pkg::OVL_RST;
    end else if (wr) begin
      if (addr == sps_pkg::A_CTRL) begin
        ctrl_ff <= wdata[sps_pkg::CTRL_W-1:0];
      end
      if (addr == sps_pkg::A_OVL) begin
        ovl_ff <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int p = 0; p < sps_pkg::NPH; p++) begin
        for (int i = 0; i < sps_pkg::NPRM; i++) begin
          prm_ff[p][i] <= sps_pkg::sps_prm_def(4'(i));
        end
      end
    end else if (wr && sps_pkg::sps_prm_hit(addr)) begin
      prm_ff[addr[sps_pkg::PH_LSB+:3]][addr[sps_pkg::IX_LSB+:4]] <=
        wdata[7:0];
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset || !rd) begin
      rdata_ff <= '0;
    end else if (sps_pkg::sps_prm_hit(addr)) begin
      rdata_ff <= {24'h000000,
        prm_ff[addr[sps_pkg::PH_LSB+:3]][addr[sps_pkg::IX_LSB+:4]]};
    end else begin
      case (addr)
        sps_pkg::A_CTRL: rdata_ff <= {24'h000000, ctrl_ff};
        sps_pkg::A_OVL: rdata_ff <= ovl_ff;
        sps_pkg::A_STAT: rdata_ff <= {24'h000000, step_ff, st_ff};
        sps_pkg::A_CALL: rdata_ff <= {8'h00, served_ff, pcall, vcall};
        default: rdata_ff <= '0;
      endcase
    end
  end

  assign rdata = rdata_ff;

  // demand seen by the sequencer
  assign conflict = |(demand & ~served_ff);
  assign any_dem = |demand;
  assign yel = {8{st_ff == sps_pkg::ST_YEL}} & served_ff;
  // rest stays green unless someone else waits (or red rest with none)
  assign term = st_ff == sps_pkg::ST_GREEN && !ent_ff &&
                &(done | ~served_ff) &&
                (conflict || (ctrl_ff.red_rest && !any_dem));

  for (genvar p = 0; p < sps_pkg::NPH; p++) begin : g_ph
    logic [2:0] mode;
    logic maxrec, pedrec, max_exp, walk_start;
    logic [7:0] max_lim;
    logic [7:0] min_cnt_ff, ext_cnt_ff, max_cnt_ff, walk_cnt_ff, pclr_cnt_ff;
    logic run_ff, vcall_ff, pcall_ff, kept_ff;

    assign mode = prm_ff[p][sps_pkg::P_MODE][2:0];
    assign maxrec = mode == sps_pkg::M_MAXREC;
    assign pedrec = mode == sps_pkg::M_PEDREC;
    assign grn[p] = st_ff == sps_pkg::ST_GREEN && served_ff[p];
    assign demand[p] = vcall_ff | pcall_ff | kept_ff | maxrec | pedrec;
    assign walk_on[p] = walk_cnt_ff != '0;
    assign pclr_on[p] = pclr_cnt_ff != '0;
    assign vcall[p] = vcall_ff;
    assign pcall[p] = pcall_ff;
    assign max_lim = (ctrl_ff.alt_max || alt_max_in) ?
                     prm_ff[p][sps_pkg::P_MAX2] :
                     prm_ff[p][sps_pkg::P_MAX1];
    assign max_exp = run_ff && max_cnt_ff == '0;
    // recycle needs a real button call, so ped recall alone cannot loop
    assign walk_start = grn[p] && (ent_ff ? (pcall_ff || pedrec) :
                        (!walk_on[p] && !pclr_on[p] && !conflict &&
                         pcall_ff));
    assign done[p] = min_cnt_ff == '0 && !walk_on[p] && !pclr_on[p] &&
                     !walk_start &&
                     (max_exp || (!maxrec && ext_cnt_ff == '0));

    // vehicle green timing
    always_ff @(posedge clk) begin
      if (reset) begin
        min_cnt_ff <= '0;
        ext_cnt_ff <= '0;
        max_cnt_ff <= '0;
        run_ff <= 1'b0;
      end else if (grn[p] && ent_ff) begin
        min_cnt_ff <= prm_ff[p][sps_pkg::P_MIN];
        ext_cnt_ff <= '0;
        max_cnt_ff <= max_lim;
        run_ff <= maxrec;
      end else if (grn[p]) begin
        if (veh_det[p]) begin
          ext_cnt_ff <= prm_ff[p][sps_pkg::P_EXT];
        end else if (tick && ext_cnt_ff != '0) begin
          ext_cnt_ff <= ext_cnt_ff - 1'b1;
        end
        if (tick && min_cnt_ff != '0) begin
          min_cnt_ff <= min_cnt_ff - 1'b1;
        end
        if (conflict && !run_ff) begin
          run_ff <= 1'b1;
          max_cnt_ff <= max_lim;
        end
        if (tick && run_ff && max_cnt_ff != '0) begin
          max_cnt_ff <= max_cnt_ff - 1'b1;
        end
      end else begin
        ext_cnt_ff <= '0;
        run_ff <= 1'b0;
      end
    end

    // pedestrian timing inside green
    always_ff @(posedge clk) begin
      if (reset || !grn[p]) begin
        walk_cnt_ff <= '0;
        pclr_cnt_ff <= '0;
      end else if (walk_start) begin
        walk_cnt_ff <= prm_ff[p][sps_pkg::P_WALK];
        pclr_cnt_ff <= '0;
      end else if (tick) begin
        if (walk_cnt_ff == 8'h01) begin
          pclr_cnt_ff <= prm_ff[p][sps_pkg::P_PCLR];
        end
        if (walk_on[p]) begin
          walk_cnt_ff <= walk_cnt_ff - 1'b1;
        end else if (pclr_on[p]) begin
          pclr_cnt_ff <= pclr_cnt_ff - 1'b1;
        end
      end
    end

    // call memory
    always_ff @(posedge clk) begin
      if (reset || restart) begin
        vcall_ff <= 1'b1;
        pcall_ff <= 1'b1;
        kept_ff <= 1'b0;
      end else begin
        case (mode)
          sps_pkg::M_NONLOCK: vcall_ff <= veh_det[p];
          sps_pkg::M_VREC: vcall_ff <= !grn[p];
          default: vcall_ff <= !grn[p] && (veh_det[p] || vcall_ff);
        endcase
        if (grn[p] && term && ext_cnt_ff != '0) begin
          kept_ff <= 1'b1;
        end else if (grn[p]) begin
          kept_ff <= 1'b0;
        end
        // a press in the walk-start cycle wins over the clear
        if (ped_btn[p] && !walk_on[p]) begin
          pcall_ff <= 1'b1;
        end else if (walk_start) begin
          pcall_ff <= 1'b0;
        end
      end
    end
  end

  // overlaps
  for (genvar o = 0; o < sps_pkg::NOVL; o++) begin : g_ovl
    assign ovl_g[o] = |(grn & ovl_ff[8*o+:8]);
    assign ovl_y[o] = !ovl_g[o] && |(yel & ovl_ff[8*o+:8]);
  end

  // next step with demand, current step last
  always_comb begin
    nxt_step = step_ff;
    found = 1'b0;
    for (int i = 1; i <= sps_pkg::NPH; i++) begin
      if (!found && (ctrl_ff.single_ring || i <= sps_pkg::NPH / 2) &&
          (sps_pkg::sps_step_mask(3'(step_ff + 3'(i)),
           ctrl_ff.single_ring) & demand) != '0) begin
        found = 1'b1;
        nxt_step = ctrl_ff.single_ring ? 3'(step_ff + 3'(i)) :
                   {1'b0, 2'(step_ff + 3'(i))};
      end
    end
  end

  // clearance is as long as the longest served phase needs
  always_comb begin
    yel_max = '0;
    red_max = '0;
    for (int p = 0; p < sps_pkg::NPH; p++) begin
      if (served_ff[p] && prm_ff[p][sps_pkg::P_YEL] > yel_max) begin
        yel_max = prm_ff[p][sps_pkg::P_YEL];
      end
      if (served_ff[p] && prm_ff[p][sps_pkg::P_RED] > red_max) begin
        red_max = prm_ff[p][sps_pkg::P_RED];
      end
    end
  end

  // interval sequence
  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= sps_pkg::ST_GREEN;
      ent_ff <= 1'b1;
      step_ff <= '0;
      served_ff <= sps_pkg::SERVED_RST;
    end else if (restart) begin
      case (rs_cfg.init_int)
        sps_pkg::I_YEL: st_ff <= sps_pkg::ST_YEL;
        sps_pkg::I_RED: st_ff <= sps_pkg::ST_RED;
        default: st_ff <= sps_pkg::ST_GREEN;
      endcase
      ent_ff <= 1'b1;
      step_ff <= rs_cfg.single_ring ? rs_cfg.init_step :
                 {1'b0, rs_cfg.init_step[1:0]};
      served_ff <= sps_pkg::sps_step_mask(rs_cfg.init_step,
                                          rs_cfg.single_ring);
    end else begin
      ent_ff <= 1'b0;
      case (st_ff)
        sps_pkg::ST_GREEN: begin
          if (term) begin
            st_ff <= sps_pkg::ST_YEL;
            ent_ff <= 1'b1;
          end
        end
        sps_pkg::ST_YEL: begin
          if (!ent_ff && cl_cnt_ff == '0) begin
            st_ff <= sps_pkg::ST_RED;
            ent_ff <= 1'b1;
          end
        end
        sps_pkg::ST_RED: begin
          if (!ent_ff && cl_cnt_ff == '0) begin
            st_ff <= sps_pkg::ST_SEL;
          end
        end
        sps_pkg::ST_SEL: begin
          if (found) begin
            st_ff <= sps_pkg::ST_GREEN;
            ent_ff <= 1'b1;
            step_ff <= nxt_step;
            // only demanded phases of the step, both from one barrier side
            served_ff <= sps_pkg::sps_step_mask(nxt_step,
                         ctrl_ff.single_ring) & demand;
          end else begin
            st_ff <= sps_pkg::ST_ALLRED;
          end
        end
        sps_pkg::ST_ALLRED: begin
          if (any_dem) begin
            st_ff <= sps_pkg::ST_SEL;
          end
        end
        default: st_ff <= sps_pkg::ST_SEL;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cl_cnt_ff <= '0;
    end else if (ent_ff && st_ff == sps_pkg::ST_YEL) begin
      cl_cnt_ff <= yel_max;
    end else if (ent_ff && st_ff == sps_pkg::ST_RED) begin
      cl_cnt_ff <= red_max;
    end else if (tick && cl_cnt_ff != '0) begin
      cl_cnt_ff <= cl_cnt_ff - 1'b1;
    end
  end

  // load switch drivers
  always_ff @(posedge clk) begin
    if (reset) begin
      grn_o_ff <= '0;
      yel_o_ff <= '0;
      red_o_ff <= '1;
      walk_o_ff <= '0;
      pclr_o_ff <= '0;
      hold_o_ff <= '1;
      og_ff <= '0;
      oy_ff <= '0;
      or_ff <= '1;
    end else begin
      grn_o_ff <= grn;
      yel_o_ff <= yel;
      red_o_ff <= ~(grn | yel);
      walk_o_ff <= grn & walk_on;
      pclr_o_ff <= grn & pclr_on;
      hold_o_ff <= ~((grn & walk_on) | (grn & pclr_on));
      og_ff <= ovl_g;
      oy_ff <= ovl_y;
      or_ff <= ~(ovl_g | ovl_y);
    end
  end

  assign sig_green = grn_o_ff;
  assign sig_yellow = yel_o_ff;
  assign sig_red = red_o_ff;
  assign ped_walk = walk_o_ff;
  assign ped_clear = pclr_o_ff;
  assign ped_hold = hold_o_ff;
  assign ovl_green = og_ff;
  assign ovl_yellow = oy_ff;
  assign ovl_red = or_ff;
endmodule

/* File: verif/sps_core_chk.sv */
// port-level assertion checker for the phase sequencer
`timescale 1ns/1ps
module sps_core_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic ext_restart,
  input wire logic [7:0] sig_green,
  input wire logic [7:0] sig_yellow,
  input wire logic [7:0] sig_red,
  input wire logic [7:0] ped_walk,
  input wire logic [7:0] ped_clear,
  input wire logic [7:0] ped_hold,
  input wire logic [3:0] ovl_green
);
  logic [3:0] rs_ff;
  logic [7:0] omask_ff;
  logic [1:0] oage_ff;
  logic ctl_rs;
  logic quiet;
  assign ctl_rs = wr && addr == sps_pkg::A_CTRL &&
                  wdata[sps_pkg::RESTART_BIT];
  // restart jumps intervals on purpose, so clearance checks pause
  assign quiet = rs_ff == 4'h0;
  always_ff @(posedge clk) begin
    if (reset) begin
      rs_ff <= 4'h0;
    end else begin
      rs_ff <= {rs_ff[2:0], ext_restart | ctl_rs};
    end
  end
  // overlap mask mirrored from bus writes; outputs lag it by a few clocks
  always_ff @(posedge clk) begin
    if (reset) begin
      omask_ff <= 8'h00;
      oage_ff <= 2'h0;
    end else if (wr && addr == sps_pkg::A_OVL) begin
      omask_ff <= wdata[7:0];
      oage_ff <= 2'h0;
    end else if (oage_ff != 2'h3) begin
      oage_ff <= oage_ff + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_grn_pair;
    $onehot0(sig_green[3:0]) && $onehot0(sig_green[7:4]) &&
    (sig_green[3:0] == 4'h0 || sig_green[7:4] == 4'h0 ||
     sig_green[3:0] == sig_green[7:4]);
  endproperty
  a_grn_pair: assert property (p_grn_pair)
    else $error("conflicting greens");
  property p_walk_grn;
    (ped_walk & ~sig_green) == 8'h00;
  endproperty
  a_walk_grn: assert property (p_walk_grn)
    else $error("walk without green");
  property p_hold;
    ped_hold == ~(ped_walk | ped_clear);
  endproperty
  a_hold: assert property (p_hold)
    else $error("steady hold wrong");
  property p_color;
    ((sig_green & sig_yellow) | (sig_green & sig_red) |
     (sig_yellow & sig_red)) == 8'h00 &&
    (sig_green | sig_yellow | sig_red) == 8'hff;
  endproperty
  a_color: assert property (p_color)
    else $error("phase colour not exclusive");
  property p_g2y;
    quiet && ($past(sig_green) & ~sig_green) != 8'h00 |->
      ($past(sig_green) & ~sig_green & ~sig_yellow) == 8'h00;
  endproperty
  a_g2y: assert property (p_g2y)
    else $error("green ended without yellow");
  property p_y2r;
    quiet && ($past(sig_yellow) & ~sig_yellow) != 8'h00 |->
      ($past(sig_yellow) & ~sig_yellow & ~sig_red) == 8'h00;
  endproperty
  a_y2r: assert property (p_y2r)
    else $error("yellow ended without red");
  property p_ovl;
    oage_ff == 2'h3 && (omask_ff & sig_green) != 8'h00 |-> ovl_green[0];
  endproperty
  a_ovl: assert property (p_ovl)
    else $error("overlap not following phase");
  property p_rs_red;
    ctl_rs && wdata[4:3] == sps_pkg::I_RED |->
      ##3 (sig_green | sig_yellow) == 8'h00;
  endproperty
  a_rs_red: assert property (p_rs_red)
    else $error("restart red not shown");
  c_pair: cover property (sig_green == 8'h11);
  c_walk: cover property (ped_walk != 8'h00);
  c_ovl: cover property (ovl_green[0]);
  c_allred: cover property (sig_red == 8'hff);
endmodule

/* File: verif/sps_field.sv */
// field model: detectors, push buttons and load switch monitor
`timescale 1ns/1ps
module sps_field (
  input wire logic clk,
  input wire logic [7:0] det_req,
  input wire logic [7:0] btn_req,
  input wire logic [7:0] sig_green,
  output logic [7:0] veh_det,
  output logic [7:0] ped_btn
);
  int serve_cnt [8] = '{8{0}};
  int run_len [8] = '{8{0}};
  int last_len [8] = '{8{0}};
  logic [7:0] g_q = 8'h00;
  // contact closures with no bounce; the core samples them raw
  assign veh_det = det_req;
  assign ped_btn = btn_req;
  // count green starts and time each green at the load switches
  always @(posedge clk) begin
    for (int p = 0; p < 8; p++) begin
      if (sig_green[p] && !g_q[p]) begin
        serve_cnt[p]++;
      end
      if (sig_green[p]) begin
        run_len[p]++;
      end else if (g_q[p]) begin
        last_len[p] = run_len[p];
        run_len[p] = 0;
      end
    end
    g_q = sig_green;
  end
endmodule

/* File: verif/test_signal_phase_sequencer.sv */
// self-checking bench for the signal phase sequencer
`timescale 1ns/1ps
module test_signal_phase_sequencer;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic alt_max_in = 1'b0;
  logic ext_restart = 1'b0;
  logic [7:0] det_req = 8'h00;
  logic [7:0] btn_req = 8'h00;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [7:0] veh_det, ped_btn, sig_green, sig_yellow, sig_red;
  logic [7:0] ped_walk, ped_clear, ped_hold;
  logic [3:0] ovl_green, ovl_yellow, ovl_red;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int c0;
  always #12.5 clk = ~clk;
  sps_core #(.TICK_CYC(TK)) dut (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .veh_det(veh_det),
    .ped_btn(ped_btn), .alt_max_in(alt_max_in), .ext_restart(ext_restart),
    .sig_green(sig_green), .sig_yellow(sig_yellow), .sig_red(sig_red),
    .ped_walk(ped_walk), .ped_clear(ped_clear), .ped_hold(ped_hold),
    .ovl_green(ovl_green), .ovl_yellow(ovl_yellow), .ovl_red(ovl_red));
  sps_field fld (.clk(clk), .det_req(det_req), .btn_req(btn_req),
    .sig_green(sig_green), .veh_det(veh_det), .ped_btn(ped_btn));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // whole run is a few thousand clocks; this ceiling only cuts a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic setp(input int p, input int i, input logic [7:0] v);
    wr_reg(12'(32'h200 + p * 64 + i * 4), {24'h0, v});
  endtask
  // wait for all bits of m on green, walk or hold within n clocks
  task automatic see(input string nm, input logic [1:0] sel,
                     input logic [7:0] m, input int n);
    logic hit;
    logic [7:0] v;
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      @(posedge clk);
      #1;
      v = sel == 2'h0 ? sig_green : sel == 2'h1 ? ped_walk : ped_hold;
      hit = (v & m) == m;
    end
    chk(nm, 32'h1, {31'h0, hit});
  endtask
  task automatic pulse(input logic [7:0] m, input logic btn);
    @(posedge clk);
    det_req <= btn ? det_req : (det_req | m);
    btn_req <= btn ? m : 8'h00;
    @(posedge clk);
    det_req <= det_req & ~m;
    btn_req <= 8'h00;
  endtask
  // detector held on phase 4, conflict on phase 1; green must end at max
  task automatic max_run(input int t);
    int n;
    @(posedge clk);
    det_req <= 8'h08;
    see("ext green", 2'h0, 8'h08, 400);
    pulse(8'h01, 1'b0);
    n = 1;
    while (sig_green[3] && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("max length", 32'h1, {31'h0, n >= (t - 1) * TK &&
        n <= (t + 1) * TK + 4});
    @(posedge clk) det_req <= 8'h00;
    see("held return", 2'h0, 8'h08, 400);
  endtask
  logic [7:0] tbl [9] = '{8'h00, 8'h02, 8'h03, 8'h08, 8'h0c, 8'h02,
                          8'h01, 8'h02, 8'h02};
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    see("init green", 2'h0, 8'h11, 4);
    see("init walk", 2'h1, 8'h11, 4);
    for (int p = 0; p < 8; p++) begin
      for (int i = 1; i < 9; i++) begin
        setp(p, i, tbl[i]);
      end
    end
    repeat (2000) @(posedge clk);
    for (int p = 0; p < 8; p++) begin
      chk("served once", 32'h1, {31'h0, fld.serve_cnt[p] == 1});
    end
    chk("rest green", 32'h88, {24'h0, sig_green});
    rd_reg(sps_pkg::A_STAT, d);
    chk("rest state", 32'h01, {27'h0, d[4:0]});
    pulse(8'h04, 1'b0);
    see("locked call", 2'h0, 8'h04, 300);
    chk("lone phase", 32'h04, {24'h0, sig_green});
    setp(3, 0, sps_pkg::M_NONLOCK);
    c0 = fld.serve_cnt[3];
    pulse(8'h08, 1'b0);
    repeat (300) @(posedge clk);
    chk("presence drop", c0, fld.serve_cnt[3]);
    max_run(8);
    @(posedge clk) alt_max_in <= 1'b1;
    max_run(12);
    @(posedge clk) alt_max_in <= 1'b0;
    wr_reg(sps_pkg::A_CTRL, 32'h1);
    max_run(12);
    wr_reg(sps_pkg::A_CTRL, 32'h0);
    setp(5, 0, sps_pkg::M_VREC);
    see("veh recall", 2'h0, 8'h20, 400);
    setp(1, 0, sps_pkg::M_PEDREC);
    see("ped recall", 2'h1, 8'h02, 400);
    setp(0, 0, sps_pkg::M_MAXREC);
    see("max recall", 2'h0, 8'h01, 400);
    while (sig_green[0]) @(posedge clk);
    #1;
    chk("max recall len", 32'h1, {31'h0, fld.last_len[0] >= 7 * TK &&
        fld.last_len[0] <= 9 * TK + 4});
    setp(0, 0, sps_pkg::M_LOCK);
    setp(1, 0, sps_pkg::M_LOCK);
    setp(5, 0, sps_pkg::M_LOCK);
    repeat (400) @(posedge clk);
    pulse(8'h80, 1'b1);
    see("ped call walk", 2'h1, 8'h80, 400);
    see("hold back", 2'h2, 8'h80, 400);
    pulse(8'h80, 1'b1);
    see("ped recycle", 2'h1, 8'h80, 400);
    wr_reg(sps_pkg::A_CTRL, 32'h2);
    repeat (400) @(posedge clk);
    rd_reg(sps_pkg::A_STAT, d);
    chk("all red state", 32'h10, {27'h0, d[4:0]});
    chk("all red out", 32'hff, {24'h0, sig_red});
    pulse(8'h01, 1'b0);
    see("red rest call", 2'h0, 8'h01, 300);
    wr_reg(sps_pkg::A_CTRL, 32'h48);
    pulse(8'h00, 1'b0);
    ext_restart <= 1'b1;
    @(posedge clk);
    ext_restart <= 1'b0;
    rd_reg(sps_pkg::A_STAT, d);
    chk("restart yellow", 32'h42, {24'h0, d[7:0]});
    wr_reg(sps_pkg::A_CTRL, 32'h150);
    repeat (4) @(posedge clk);
    wr_reg(sps_pkg::A_OVL, 32'h03);
    wr_reg(sps_pkg::A_CTRL, 32'h104);
    see("single first", 2'h0, 8'h01, 40);
    chk("single alone", 32'h01, {24'h0, sig_green});
    see("single next", 2'h0, 8'h02, 600);
    chk("single alone", 32'h02, {24'h0, sig_green});
    @(posedge clk);
    #1;
    chk("overlap", 32'h1, {31'h0, ovl_green[0]});
    chk("overlap yellow", 32'h0, {28'h0, ovl_yellow});
    chk("overlap red", 32'he, {28'h0, ovl_red});
    wrap_up();
  end
endmodule
bind sps_core sps_core_chk chk (.clk(clk), .reset(reset), .addr(addr),
  .wdata(wdata), .wr(wr), .ext_restart(ext_restart),
  .sig_green(sig_green), .sig_yellow(sig_yellow), .sig_red(sig_red),
  .ped_walk(ped_walk), .ped_clear(ped_clear), .ped_hold(ped_hold),
  .ovl_green(ovl_green));
